//--- ecc_logger_consts.svh
// register offsets, field positions and reset values of the ecc error logger
`ifndef ECC_LOGGER_CONSTS_SVH
`define ECC_LOGGER_CONSTS_SVH
// register indices (byte address is index times four)
`define ECC_CTRL_IDX 10'h130
`define ECC_STATUS_IDX 10'h131
`define ECC_LOCATION_IDX 10'h132
`define ECC_IRQ_STATUS_IDX 10'h133
`define ECC_IRQ_CLEAR_IDX 10'h134
`define ECC_IRQ_ENABLE_IDX 10'h135
// control register bit positions
`define CTRL_IRQ_GATE_BIT 4
`define CTRL_SINGLE_GATE_BIT 5
`define CTRL_DOUBLE_GATE_BIT 6
`define CTRL_CLEAR_BIT 7
// status register field positions
`define STAT_SINGLE_FLAG_BIT 0
`define STAT_DOUBLE_FLAG_BIT 1
`define STAT_SINGLE_TALLY_LSB 8
`define STAT_DOUBLE_TALLY_LSB 16
// reset values and tally saturation limit
`define TALLY_RESET 8'h00
`define LOCATION_RESET 32'h00000000
`define CTRL_RESET 3'h0
`define IRQ_RESET 2'h0
`define TALLY_MAX 8'hFF
`endif

//--- ecc_logger_pkg.sv
// types shared by the ecc error logger
package ecc_logger_pkg;
	// one error report from the read datapath
	typedef struct packed {
		logic single_fault;
		logic double_fault;
		logic [31:0] location;
	} fault_report_t;
	// software register port request
	typedef struct packed {
		logic write;
		logic read;
		logic [9:0] addr;
		logic [31:0] wdata;
	} reg_req_t;
endpackage

//--- ecc_error_status_logger.sv
// ecc error status logger: flags, tallies, last error location and interrupt
//
// Function
// - clear bit wipes status, location, interrupt; self-clears
// - status bit 0 flags single-bit errors
// - status bit 1 flags double-bit errors
// - status bits 8-15 count single-bit errors
// - status bits 16-23 count double-bit errors
// - location register holds last error address
// - status bits 2-7, 24-31 read zero
// - interrupt output only while bit 4 zero
// - bit 5/6 zero suppresses single/double interrupt
`timescale 1ns/1ns
`include "ecc_logger_consts.svh"
module ecc_error_status_logger #(
	parameter int TALLY_W = 8
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// error reports from the correction datapath
	input ecc_logger_pkg::fault_report_t report_i,
	// software register port
	input ecc_logger_pkg::reg_req_t req_i,
	output logic [31:0] rdata_o,
	// interrupt
	output logic irq_o
);
	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (TALLY_W != 8)
	begin : g_bad_width
		$error("tally width must be 8");
	end

	// ----------------------------------------------------------------
	// state and decode
	// ----------------------------------------------------------------
	// control gates: [0] output gate, [1] single mask, [2] double mask
	logic [2:0] ctrl_q;
	// sticky error flags
	logic single_flag_q;
	logic double_flag_q;
	// saturating error tallies
	logic [TALLY_W-1:0] single_tally_q;
	logic [TALLY_W-1:0] double_tally_q;
	// last error location
	logic [31:0] location_q;
	// interrupt status, its next value and enable, bit 0 single, bit 1 double
	logic [1:0] irq_stat_q;
	logic [1:0] irq_stat_d;
	logic [1:0] irq_en_q;
	// decoded strobes and per-kind report hits
	logic [1:0] fault_hit;
	logic irq_clr_wr;
	logic irq_en_wr;
	logic clear_pulse;
	logic ctrl_wr;
	// read path words
	logic [31:0] status_word;
	logic [31:0] ctrl_word;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	assign ctrl_wr = req_i.write && req_i.addr == `ECC_CTRL_IDX;
	// clear bit is never stored, so it reads back zero
	assign clear_pulse = ctrl_wr && req_i.wdata[`CTRL_CLEAR_BIT];

	// gates for interrupt output and per-kind interrupts
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ctrl_q <= `CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= req_i.wdata[`CTRL_DOUBLE_GATE_BIT:`CTRL_IRQ_GATE_BIT];
	end

	// ----------------------------------------------------------------
	// error flags
	// ----------------------------------------------------------------
	// a report in the clear cycle wins over the clear
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			single_flag_q <= 1'b0;
			double_flag_q <= 1'b0;
		end
		else
		begin
			single_flag_q <= report_i.single_fault || (single_flag_q && !clear_pulse);
			double_flag_q <= report_i.double_fault || (double_flag_q && !clear_pulse);
		end
	end

	// ----------------------------------------------------------------
	// saturating tallies
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			single_tally_q <= `TALLY_RESET;
			double_tally_q <= `TALLY_RESET;
		end
		else
		begin
			if (report_i.single_fault)
				single_tally_q <= clear_pulse ? 8'h01 : (single_tally_q == `TALLY_MAX ? `TALLY_MAX
					: single_tally_q + 8'h01);
			else if (clear_pulse)
				single_tally_q <= `TALLY_RESET;
			if (report_i.double_fault)
				double_tally_q <= clear_pulse ? 8'h01 : (double_tally_q == `TALLY_MAX ? `TALLY_MAX
					: double_tally_q + 8'h01);
			else if (clear_pulse)
				double_tally_q <= `TALLY_RESET;
		end
	end

	// ----------------------------------------------------------------
	// last error location
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			location_q <= `LOCATION_RESET;
		else if (report_i.single_fault || report_i.double_fault)
			location_q <= report_i.location;
		else if (clear_pulse)
			location_q <= `LOCATION_RESET;
	end

	// ----------------------------------------------------------------
	// interrupt status, clear and enable
	// ----------------------------------------------------------------
	assign fault_hit = {report_i.double_fault, report_i.single_fault};
	assign irq_clr_wr = req_i.write && req_i.addr == `ECC_IRQ_CLEAR_IDX;
	assign irq_en_wr = req_i.write && req_i.addr == `ECC_IRQ_ENABLE_IDX;

	// per-kind sticky status: a report wins over a clear in the same cycle
	for (genvar k = 0; k < 2; k++)
	begin : g_irq_bit
		assign irq_stat_d[k] = fault_hit[k]
			|| (irq_stat_q[k] && !clear_pulse && !(irq_clr_wr && req_i.wdata[k]));
	end

	// status and enable registers
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			irq_stat_q <= `IRQ_RESET;
			irq_en_q <= `IRQ_RESET;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
			if (irq_en_wr)
				irq_en_q <= req_i.wdata[1:0];
		end
	end

	// mask gates pass the interrupt when one, output gate passes it when zero
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			irq_o <= 1'b0;
		else
			irq_o <= !ctrl_q[0] && !clear_pulse
				&& ((irq_stat_q[0] && irq_en_q[0] && ctrl_q[1])
				|| (irq_stat_q[1] && irq_en_q[1] && ctrl_q[2]));
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[`STAT_SINGLE_FLAG_BIT] = single_flag_q;
		status_word[`STAT_DOUBLE_FLAG_BIT] = double_flag_q;
		status_word[`STAT_SINGLE_TALLY_LSB +: TALLY_W] = single_tally_q;
		status_word[`STAT_DOUBLE_TALLY_LSB +: TALLY_W] = double_tally_q;
		ctrl_word = 32'h00000000;
		ctrl_word[`CTRL_DOUBLE_GATE_BIT:`CTRL_IRQ_GATE_BIT] = ctrl_q;
	end

	// data stand one cycle after the read strobe, zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !req_i.read)
			rdata_o <= 32'h00000000;
		else
			case (req_i.addr)
				`ECC_CTRL_IDX: rdata_o <= ctrl_word;
				`ECC_STATUS_IDX: rdata_o <= status_word;
				`ECC_LOCATION_IDX: rdata_o <= location_q;
				`ECC_IRQ_STATUS_IDX: rdata_o <= {30'h0, irq_stat_q};
				`ECC_IRQ_ENABLE_IDX: rdata_o <= {30'h0, irq_en_q};
				default: rdata_o <= 32'h00000000;
			endcase
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_clear_wipes: assert property (@(posedge clk_i) disable iff (reset_i)
		clear_pulse && !report_i.single_fault && !report_i.double_fault
		|=> !single_flag_q && !double_flag_q && single_tally_q == 8'h00 && location_q == 32'h00000000)
		else $error("clear did not wipe status");
	a_single_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
		report_i.single_fault |=> single_flag_q)
		else $error("single flag not set");
	a_double_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
		report_i.double_fault |=> double_flag_q)
		else $error("double flag not set");
	a_single_tally_step: assert property (@(posedge clk_i) disable iff (reset_i)
		report_i.single_fault && !clear_pulse && single_tally_q != 8'hFF
		|=> single_tally_q == $past(single_tally_q) + 8'h01)
		else $error("single tally did not step");
	a_double_tally_step: assert property (@(posedge clk_i) disable iff (reset_i)
		report_i.double_fault && !clear_pulse && double_tally_q != 8'hFF
		|=> double_tally_q == $past(double_tally_q) + 8'h01)
		else $error("double tally did not step");
	a_location_latch: assert property (@(posedge clk_i) disable iff (reset_i)
		report_i.single_fault || report_i.double_fault |=> location_q == $past(report_i.location))
		else $error("location not captured");
	a_status_reserved: assert property (@(posedge clk_i) disable iff (reset_i)
		req_i.read && req_i.addr == `ECC_STATUS_IDX |=> rdata_o[7:2] == 6'h00 && rdata_o[31:24] == 8'h00)
		else $error("reserved status bits nonzero");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_q[0] |=> !irq_o)
		else $error("interrupt while output gate set");
	a_mask_gate: assert property (@(posedge clk_i) disable iff (reset_i)
		!ctrl_q[1] && !ctrl_q[2] |=> !irq_o)
		else $error("interrupt while both masks zero");
	a_tally_saturate: assert property (@(posedge clk_i) disable iff (reset_i)
		single_tally_q == 8'hFF && !clear_pulse |=> single_tally_q == 8'hFF)
		else $error("single tally wrapped");

	// ----------------------------------------------------------------
	// named steps and further checks
	// ----------------------------------------------------------------
	// clear request with no report beside it
	sequence s_clear_alone;
		clear_pulse && !report_i.single_fault && !report_i.double_fault;
	endsequence
	// clear request while a single-bit report arrives
	sequence s_clear_with_single;
		clear_pulse && report_i.single_fault;
	endsequence
	// unmasked single-bit interrupt pending, output gate open
	sequence s_single_irq_ready;
		!ctrl_q[0] && !clear_pulse && irq_stat_q[0] && irq_en_q[0] && ctrl_q[1];
	endsequence
	// unmasked double-bit interrupt pending, output gate open
	sequence s_double_irq_ready;
		!ctrl_q[0] && !clear_pulse && irq_stat_q[1] && irq_en_q[1] && ctrl_q[2];
	endsequence

	// clear side effects
	a_clear_double_wipe: assert property (@(posedge clk_i) disable iff (reset_i)
		s_clear_alone |=> double_tally_q == `TALLY_RESET && irq_stat_q == `IRQ_RESET)
		else $error("clear left double tally or interrupt status");
	a_clear_drops_irq: assert property (@(posedge clk_i) disable iff (reset_i)
		clear_pulse |=> !irq_o)
		else $error("interrupt survived a clear");
	a_report_beats_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		s_clear_with_single |=> single_flag_q && single_tally_q == 8'h01)
		else $error("report lost against a clear");

	// sticky flags and last location
	a_single_flag_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		single_flag_q && !clear_pulse |=> single_flag_q)
		else $error("single flag dropped");
	a_double_flag_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		double_flag_q && !clear_pulse |=> double_flag_q)
		else $error("double flag dropped");
	a_location_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		!report_i.single_fault && !report_i.double_fault && !clear_pulse
		|=> $stable(location_q))
		else $error("location changed without a report");

	// tally fields on the read path and saturation
	a_single_tally_read: assert property (@(posedge clk_i) disable iff (reset_i)
		req_i.read && req_i.addr == `ECC_STATUS_IDX
		|=> rdata_o[`STAT_SINGLE_TALLY_LSB +: 8] == $past(single_tally_q))
		else $error("single tally misread");
	a_double_tally_read: assert property (@(posedge clk_i) disable iff (reset_i)
		req_i.read && req_i.addr == `ECC_STATUS_IDX
		|=> rdata_o[`STAT_DOUBLE_TALLY_LSB +: 8] == $past(double_tally_q))
		else $error("double tally misread");
	a_double_saturate: assert property (@(posedge clk_i) disable iff (reset_i)
		double_tally_q == `TALLY_MAX && !clear_pulse |=> double_tally_q == `TALLY_MAX)
		else $error("double tally wrapped");

	// interrupt raising and masking
	a_single_irq_raise: assert property (@(posedge clk_i) disable iff (reset_i)
		s_single_irq_ready |=> irq_o)
		else $error("single interrupt not raised");
	a_double_irq_raise: assert property (@(posedge clk_i) disable iff (reset_i)
		s_double_irq_ready |=> irq_o)
		else $error("double interrupt not raised");
	a_irq_needs_status: assert property (@(posedge clk_i) disable iff (reset_i)
		!irq_stat_q[0] && !irq_stat_q[1] |=> !irq_o)
		else $error("interrupt without pending status");
endmodule // ecc_error_status_logger

//--- fault_source.sv
// report source standing in for the correction datapath
`timescale 1ns/1ns
module fault_source (
	// clock
	input wire logic clk_i,
	// reports towards the logger
	output ecc_logger_pkg::fault_report_t report_o
);
	// idle reports carry no stale location
	initial report_o = '0;
	// one-cycle report pulse, then idle with a changed location
	task automatic send(input logic s, input logic d, input logic [31:0] loc);
		@(posedge clk_i);
		report_o <= '{s, d, loc};
		@(posedge clk_i);
		report_o <= '{1'b0, 1'b0, ~loc};
	endtask
endmodule // fault_source

//--- tb.sv
// self-checking bench of the ecc error status logger
`timescale 1ns/1ns
`include "ecc_logger_consts.svh"
module tb;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	ecc_logger_pkg::reg_req_t req_i = '0;
	ecc_logger_pkg::fault_report_t report_i;
	logic [31:0] rdata_o;
	logic irq_o;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// ----------------------------------------
	// clock, timeout and instances
	// ----------------------------------------
	always #2 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end
	fault_source fault_source_i (.clk_i(clk_i), .report_o(report_i));
	ecc_error_status_logger ecc_error_status_logger_i (.clk_i(clk_i), .reset_i(reset_i), .report_i(report_i),
		.req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o));
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic end_sim();
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_irq(input logic exp);
		#1;
		samples_checked++;
		if (irq_o !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: interrupt %b, expected %b", $time, irq_o, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req_i <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req_i <= '0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		req_i <= '{1'b0, 1'b1, a, 32'h00000000};
		@(posedge clk_i);
		req_i <= '0;
		#1 cmp_word(rdata_o, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_chk(`ECC_STATUS_IDX, 32'h00000000);
		rd_chk(`ECC_LOCATION_IDX, 32'h00000000);
		rd_chk(10'h000, 32'h00000000);
		cmp_irq(1'b0);
	endtask
	task automatic t_log();
		fault_source_i.send(1'b1, 1'b0, 32'hA5C30F1E);
		rd_chk(`ECC_STATUS_IDX, 32'h00000101);
		fault_source_i.send(1'b0, 1'b1, 32'h5A3CE1F0);
		rd_chk(`ECC_STATUS_IDX, 32'h00010103);
		rd_chk(`ECC_LOCATION_IDX, 32'h5A3CE1F0);
		wr(`ECC_STATUS_IDX, 32'hFFFFFFFF);
		rd_chk(`ECC_STATUS_IDX, 32'h00010103);
	endtask
	task automatic t_irq();
		wr(`ECC_IRQ_ENABLE_IDX, 32'h00000003);
		wr(`ECC_CTRL_IDX, 32'h00000060);
		cmp_irq(1'b1);
		wr(`ECC_CTRL_IDX, 32'h00000070);
		cmp_irq(1'b0);
		wr(`ECC_IRQ_CLEAR_IDX, 32'h00000001);
		rd_chk(`ECC_IRQ_STATUS_IDX, 32'h00000002);
		wr(`ECC_CTRL_IDX, 32'h00000020);
		cmp_irq(1'b0);
		wr(`ECC_CTRL_IDX, 32'h00000040);
		cmp_irq(1'b1);
		wr(`ECC_CTRL_IDX, 32'h000000C0);
		cmp_irq(1'b0);
		rd_chk(`ECC_STATUS_IDX, 32'h00000000);
		rd_chk(`ECC_LOCATION_IDX, 32'h00000000);
		rd_chk(`ECC_CTRL_IDX, 32'h00000040);
	endtask
	task automatic t_sat();
		repeat (260) fault_source_i.send(1'b1, 1'b0, 32'h00C0FFEE);
		rd_chk(`ECC_STATUS_IDX, 32'h0000FF01);
		// a report in the clear cycle wins: flag set, tally restarts at one
		fork
			fault_source_i.send(1'b1, 1'b0, 32'h13579BDF);
			wr(`ECC_CTRL_IDX, 32'h00000080);
		join
		rd_chk(`ECC_STATUS_IDX, 32'h00000101);
		rd_chk(`ECC_LOCATION_IDX, 32'h13579BDF);
		wr(`ECC_CTRL_IDX, 32'h00000080);
		rd_chk(`ECC_STATUS_IDX, 32'h00000000);
	endtask
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_log();
		t_irq();
		t_sat();
		end_sim();
	end
endmodule // tb
